// [core/patch_unit_defines.vh]
/*
 * constants for the rom patch trap unit: control word fields, vector offsets.
 * assumes a 32-bit control word and a 20-bit program counter.
 */
`ifndef PATCH_UNIT_DEFINES_VH
`define PATCH_UNIT_DEFINES_VH

// ----------------------------------------------------------------
// control word layout
// ----------------------------------------------------------------
`define CTL_SET_BIT 31
`define CTL_SLOT_HI 30
`define CTL_SLOT_LO 27
`define PC_WIDTH 20
`define SLOT_COUNT 16
`define SLOT_IDX_W 4

// ----------------------------------------------------------------
// trap vectors
// ----------------------------------------------------------------
`define PATCH_VEC_BASE_OFS 20'h00120
`define PATCH_VEC_STEP_SHIFT 2
`define PATCH_ICALL_FIRST 6'h30

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADDR_RESET 20'h00000
`define ENABLE_RESET 16'h0000

`endif

// [core/patch_slot_match.v]
/*
 * one patch slot: stored address and enable, compared to the fetch address.
 * assumes the writer qualifies the write strobe with this slot's index.
 */
`timescale 1ns/1ps
`include "patch_unit_defines.vh"

module patch_slot_match #(
    parameter PC_W = `PC_WIDTH
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire wr_set,
    input wire [PC_W-1:0] wr_addr,
    input wire [PC_W-1:0] fetch_addr,
    output wire hit
);
    reg [PC_W-1:0] addr_reg;
    reg en_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= {PC_W{1'b0}};
            en_reg <= 1'b0;
        end else if (wr_en) begin
            en_reg <= wr_set;
            if (wr_set) begin
                addr_reg <= wr_addr;
            end
        end
    end

    assign hit = en_reg && (fetch_addr == addr_reg);
endmodule // patch_slot_match

// [core/rom_patch_trap_unit.v]
/*
 * rom patch trap unit: sixteen write-only address slots that trap fetches.
 * assumes the sequencer presents each fetch address with a valid strobe,
 * holds the instruction when a trap is raised, and signals trap return.
 */
//
// Summary of operation
// - sixteen slots, each address plus enable
// - control word write only, no readback
// - reset disables every slot
// - bit 31 set programs, clear disables
// - enabled match raises trap to slot vector
// - target is vbase plus 0x120 plus 4n
// - slot n shares software interrupt 48+n
// - patch trap beats every hardware interrupt
// - patched address saved as trap return
// - reset by pin or core soft reset bit
// - unmaskable, no nesting, status word untouched
`timescale 1ns/1ps
`include "patch_unit_defines.vh"

module rom_patch_trap_unit #(
    parameter PC_W = `PC_WIDTH,
    parameter NSLOT = `SLOT_COUNT
) (
    input wire MCLK,
    input wire RSTN,
    input wire CORE_SOFT_RESET_BIT,
    input wire CTL_WR,
    input wire [31:0] CTL_WDATA,
    input wire FETCH_VALID,
    input wire [PC_W-1:0] FETCH_ADDR,
    input wire [PC_W-1:0] VBASE,
    input wire HW_IRQ_REQ,
    input wire TRAP_RETURN,
    output reg TRAP_REQ,
    output reg SUPPRESS_EXEC,
    output reg [PC_W-1:0] TRAP_TARGET,
    output reg [PC_W-1:0] TRAP_RETURN_ADDR,
    output reg [3:0] TRAP_SLOT,
    output reg [5:0] SHARED_ICALL_NUM,
    output reg IN_TRAP,
    output reg HW_IRQ_GRANT
);
    // ----------------------------------------------------------------
    // reset: pin or cleared core soft reset bit
    // ----------------------------------------------------------------
    wire rst_n = RSTN & CORE_SOFT_RESET_BIT;

    // ----------------------------------------------------------------
    // priority encoder, lowest slot first
    // ----------------------------------------------------------------
    function [4:0] first_hit;
        input [NSLOT-1:0] v;
        integer k;
        begin
            first_hit = 5'h00;
            for (k = NSLOT - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_hit = {1'b1, k[3:0]};
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // slot array; control word decode
    // ----------------------------------------------------------------
    wire [3:0] wr_slot = CTL_WDATA[`CTL_SLOT_HI:`CTL_SLOT_LO];
    wire wr_set = CTL_WDATA[`CTL_SET_BIT];
    wire [PC_W-1:0] wr_addr = CTL_WDATA[PC_W-1:0];
    wire [NSLOT-1:0] hits;

    // no read path exists for slot contents
    genvar g;
    generate
        for (g = 0; g < NSLOT; g = g + 1) begin : slot
            patch_slot_match #(
                .PC_W(PC_W)
            ) u_slot (
                .clk(MCLK),
                .rst_n(rst_n),
                .wr_en(CTL_WR && (wr_slot == g)),
                .wr_set(wr_set),
                .wr_addr(wr_addr),
                .fetch_addr(FETCH_ADDR),
                .hit(hits[g])
            );
        end
    endgenerate

    wire [4:0] sel = first_hit(hits);
    wire match = FETCH_VALID && sel[4] && !IN_TRAP;
    wire [PC_W-1:0] vec_ofs = `PATCH_VEC_BASE_OFS
        + ({{(PC_W-4){1'b0}}, sel[3:0]} << `PATCH_VEC_STEP_SHIFT);

    // ----------------------------------------------------------------
    // trap output registers
    // ----------------------------------------------------------------
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            TRAP_REQ <= 1'b0;
            SUPPRESS_EXEC <= 1'b0;
            TRAP_TARGET <= `ADDR_RESET;
            TRAP_RETURN_ADDR <= `ADDR_RESET;
            TRAP_SLOT <= 4'h0;
            SHARED_ICALL_NUM <= 6'h00;
            IN_TRAP <= 1'b0;
            HW_IRQ_GRANT <= 1'b0;
        end else begin
            TRAP_REQ <= match;
            SUPPRESS_EXEC <= match;
            // hardware interrupt only when no patch trap and no handler
            HW_IRQ_GRANT <= HW_IRQ_REQ && !match && !IN_TRAP;
            if (match) begin
                TRAP_TARGET <= VBASE + vec_ofs;
                TRAP_RETURN_ADDR <= FETCH_ADDR;
                TRAP_SLOT <= sel[3:0];
                SHARED_ICALL_NUM <= `PATCH_ICALL_FIRST + {2'b00, sel[3:0]};
                IN_TRAP <= 1'b1;
            end else if (TRAP_RETURN) begin
                IN_TRAP <= 1'b0;
            end
        end
    end
endmodule // rom_patch_trap_unit

// [test/rpt_props_properties.sv]
/* output checks for the patch trap unit.
   assumes binding onto rom_patch_trap_unit. */
`timescale 1ns/1ps
module rpt_props #(parameter PC_W = 20) (
    input wire MCLK, RSTN, CORE_SOFT_RESET_BIT, FETCH_VALID, HW_IRQ_REQ,
    input wire TRAP_REQ, SUPPRESS_EXEC, IN_TRAP, HW_IRQ_GRANT,
    input wire [PC_W-1:0] FETCH_ADDR, VBASE, TRAP_TARGET, TRAP_RETURN_ADDR,
    input wire [3:0] TRAP_SLOT,
    input wire [5:0] SHARED_ICALL_NUM
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN || !CORE_SOFT_RESET_BIT);
    property p_sup; SUPPRESS_EXEC == TRAP_REQ; endproperty
    a_sup: assert property (p_sup) else $error("suppress");
    property p_tgt; TRAP_REQ |-> TRAP_TARGET == $past(VBASE) + 20'h00120 + {TRAP_SLOT, 2'b00};
    endproperty
    a_tgt: assert property (p_tgt) else $error("target");
    property p_icl; TRAP_REQ |-> SHARED_ICALL_NUM == 6'h30 + TRAP_SLOT; endproperty
    a_icl: assert property (p_icl) else $error("icall");
    property p_ret; TRAP_REQ |-> TRAP_RETURN_ADDR == $past(FETCH_ADDR); endproperty
    a_ret: assert property (p_ret) else $error("return addr");
    property p_cau; TRAP_REQ |-> $past(FETCH_VALID) && !$past(IN_TRAP); endproperty
    a_cau: assert property (p_cau) else $error("cause");
    property p_nst; TRAP_REQ |-> IN_TRAP ##1 !TRAP_REQ; endproperty
    a_nst: assert property (p_nst) else $error("nesting");
    property p_irq; HW_IRQ_GRANT |-> !TRAP_REQ && $past(HW_IRQ_REQ) && !$past(IN_TRAP); endproperty
    a_irq: assert property (p_irq) else $error("grant");
    property p_hld; !TRAP_REQ |-> $stable(TRAP_SLOT); endproperty
    a_hld: assert property (p_hld) else $error("slot hold");
endmodule // rpt_props
bind rom_patch_trap_unit rpt_props #(.PC_W(PC_W)) u_props (.MCLK(MCLK), .RSTN(RSTN),
    .CORE_SOFT_RESET_BIT(CORE_SOFT_RESET_BIT), .FETCH_VALID(FETCH_VALID),
    .HW_IRQ_REQ(HW_IRQ_REQ), .TRAP_REQ(TRAP_REQ), .SUPPRESS_EXEC(SUPPRESS_EXEC),
    .IN_TRAP(IN_TRAP), .HW_IRQ_GRANT(HW_IRQ_GRANT), .FETCH_ADDR(FETCH_ADDR),
    .VBASE(VBASE), .TRAP_TARGET(TRAP_TARGET), .TRAP_RETURN_ADDR(TRAP_RETURN_ADDR),
    .TRAP_SLOT(TRAP_SLOT), .SHARED_ICALL_NUM(SHARED_ICALL_NUM));

// [test/trap_seq_model.sv]
/* sequencer model: runs a short handler, then pulses trap return.
   assumes trap_req is a one-cycle pulse. */
`timescale 1ns/1ps
module trap_seq_model (input wire clk, input wire trap_req, output reg trap_return);
    reg [2:0] cnt = 3'h0;
    initial trap_return = 1'b0;
    always @(posedge clk) begin
        trap_return <= #1 (cnt == 3'h1);
        cnt <= trap_req ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    end
endmodule // trap_seq_model

// [test/rom_patch_trap_unit_bench.sv]
/* bench for the patch trap unit: program slots, fetch, check traps.
   assumes the sequencer model answers each trap. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
    n_errors = n_errors + 1; $display("mismatch %s exp %h got %h", nm, e, g); end end
module rom_patch_trap_unit_bench;
    reg mclk = 0, rst_n = 0, srst_n = 1, we = 0, fv = 0, irq = 1;
    reg [31:0] wd = 0;
    reg [19:0] fa = 0;
    wire req, in_t, gnt, ret, sup;
    wire [19:0] tgt, ra;
    wire [3:0] sl;
    wire [5:0] ic;
    integer n_errors = 0, n_checks = 0, n;
    localparam [19:0] VB = 20'h40000;
    initial forever #12.5 mclk = ~mclk;
    rom_patch_trap_unit dut (.MCLK(mclk), .RSTN(rst_n), .CORE_SOFT_RESET_BIT(srst_n),
        .CTL_WR(we), .CTL_WDATA(wd), .FETCH_VALID(fv), .FETCH_ADDR(fa), .VBASE(VB),
        .HW_IRQ_REQ(irq), .TRAP_RETURN(ret), .TRAP_REQ(req), .SUPPRESS_EXEC(sup),
        .TRAP_TARGET(tgt), .TRAP_RETURN_ADDR(ra), .TRAP_SLOT(sl),
        .SHARED_ICALL_NUM(ic), .IN_TRAP(in_t), .HW_IRQ_GRANT(gnt));
    trap_seq_model seq (.clk(mclk), .trap_req(req), .trap_return(ret));
    task final_report; begin
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end endtask
    // ignored bits 26:20 are set on purpose
    task wr(input s, input [3:0] k); begin
        wd = {s, k, 7'h7F, k, 16'h5A5A};
        we = 1;
        @(posedge mclk) #1 we = 0;
    end endtask
    task fetch(input [19:0] a, input e, input [3:0] k); begin
        fa = a;
        fv = 1;
        @(posedge mclk) #1 fv = 0;
        `CHK("req", e, req)
        `CHK("suppress", e, sup)
        if (e) begin
            `CHK("tgt", VB + 20'h00120 + {k, 2'b00}, tgt)
            `CHK("icall", 6'h30 + k, ic)
            `CHK("ret", a, ra)
            `CHK("slot", k, sl)
            `CHK("grant", 1'b0, gnt)
        end
    end endtask
    task wt; integer i; begin
        for (i = 0; i < 9 && in_t !== 1'b0; i = i + 1) @(posedge mclk) #1;
        if (i == 9) begin n_errors = n_errors + 1; final_report; end
    end endtask
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst_n = 1;
        fetch(20'h00000, 0, 0);
        for (n = 0; n < 16; n = n + 1) begin
            wr(1, n[3:0]);
            fetch({n[3:0], 16'h5A5A}, 1, n[3:0]);
            wt;
        end
        $display("slot test done");
        wr(0, 4'hF);
        fetch(20'hF5A5A, 0, 0);
        fetch(20'h05A5B, 0, 0);
        fetch(20'h05A5A, 1, 0);
        @(posedge mclk) #1;
        fetch(20'h15A5A, 0, 0);
        wt;
        $display("nest test done");
        srst_n = 0;
        @(posedge mclk) #1 srst_n = 1;
        fetch(20'h05A5A, 0, 0);
        `CHK("grant", 1'b1, gnt)
        $display("reset test done");
        final_report;
    end
endmodule // rom_patch_trap_unit_bench
